//--- common/fcb_pkg.sv
// Purpose: Shared constants and helpers for the continuous burst read link.
// Assumes: One system clock at 250 MHz on both ends.
package fcb_pkg;

  // ****************************************
  // Sizes and configuration layout
  // ****************************************
  localparam int ADDR_W_DEF = 24;
  localparam int BANK_W_DEF = 4;
  localparam int DATA_W = 16;
  localparam int READ_MODE_POS = 15;
  localparam int WAIT_LSB = 11;
  localparam int WAIT_W = 3;
  localparam logic [3:0] WAIT_BASE = 4'h2;
  localparam logic [15:0] CFG_RESET = 16'hA800;
  localparam logic [6:0] PEN_WORD = 7'h78;
  localparam logic [4:0] PEN_BIAS = 5'h09;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 250;
  localparam int BCLK_HALF_NS = 32;
  localparam int BCLK_HALF_CYC = (BCLK_HALF_NS * CLK_MHZ + 999) / 1000;

  // Wait states for the boundary: offset plus initial wait less nine, floored at zero.
  function automatic logic [2:0] fcb_penalty(input logic [3:0] ws, input logic [2:0] off);
    logic [4:0] sum;
    sum = {1'b0, ws} + {2'b00, off};
    fcb_penalty = (sum > PEN_BIAS) ? 3'(sum - PEN_BIAS) : 3'h0;
  endfunction

endpackage

//--- common/fcb_link_if.sv
`timescale 1ns/10ps
// Purpose: Pin bundle between the host controller and the flash read path.
// Assumes: Data bus is two-way; the wire level is resolved here from the enables.
// Notes: Undriven bus reads as zero.
interface fcb_link_if #(parameter int ADDR_W = 24);
  logic burst_clk;
  logic chip_sel_n;
  logic address_valid_strobe_n;
  logic cfg_write_n;
  logic link_reset_n;
  logic [ADDR_W-1:0] addr;
  logic [15:0] dq_host;
  logic dq_host_oe;
  logic [15:0] dq_dev;
  logic dq_dev_oe;
  logic ready;
  logic [15:0] dq;

  // Bus level from whichever end drives it.
  assign dq = dq_dev_oe ? dq_dev : (dq_host_oe ? dq_host : 16'h0000);

  modport dev (input burst_clk, chip_sel_n, address_valid_strobe_n, cfg_write_n,
               link_reset_n, addr, dq, output dq_dev, dq_dev_oe, ready);
  modport host (output burst_clk, chip_sel_n, address_valid_strobe_n, cfg_write_n,
                link_reset_n, addr, dq_host, dq_host_oe, input dq, ready);
endinterface

//--- logic/fcb_host.sv
`timescale 1ns/10ps
// Purpose: Host end; makes the burst clock, configures, starts and stops bursts.
// Assumes: Pins other than the link reset change on the falling burst clock edge, stable at the rising one.
// Notes: Words are sampled in the cycle before each rising edge.
module fcb_host
  import fcb_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int HALF_CYC = BCLK_HALF_CYC
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // User requests.
  input wire logic start,
  input wire logic [ADDR_W-1:0] start_addr,
  input wire logic stop,
  input wire logic cfg_req,
  input wire logic [15:0] cfg_value,
  input wire logic link_reset_req,
  // User results.
  output logic word_valid,
  output logic [15:0] word_data,
  output logic busy,
  // Link pins.
  fcb_link_if.host link
);

  typedef enum logic [1:0] {H_IDLE = 2'b00, H_CFG = 2'b01, H_AVD = 2'b10, H_RUN = 2'b11} fcb_hst_e;

  fcb_hst_e st_r;
  logic [7:0] div_r;
  logic bclk_r, cs_n_r, avd_n_r, we_n_r, oe_r, lrst_n_r;
  logic [ADDR_W-1:0] addr_r, paddr_r;
  logic [15:0] dqo_r, pval_r, wdata_r;
  logic pstart_r, pcfg_r, pstop_r, wvalid_r;
  logic [16:0] sy1_r, sy2_r;

  // Divider edges and request acceptance.
  wire div_end = (div_r == 8'(HALF_CYC - 1));
  wire fall_now = div_end & bclk_r;
  wire rise_now = div_end & ~bclk_r;
  wire take_start = start & (st_r == H_IDLE || st_r == H_RUN);
  wire take_cfg = cfg_req & (st_r == H_IDLE) & ~pstart_r;

  // Divider forms the burst clock from the system clock.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      div_r <= 8'h00;
      bclk_r <= 1'b0;
    end else begin
      div_r <= div_end ? 8'h00 : div_r + 8'h01;
      bclk_r <= div_end ? ~bclk_r : bclk_r;
    end
  end

  // Two flip-flops on the inputs coming back from the device.
  always_ff @(posedge clock) begin
    sy1_r <= {link.ready, link.dq};
    sy2_r <= sy1_r;
  end

  // Request latches hold until the next falling edge acts on them.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pstart_r <= 1'b0;
      pcfg_r <= 1'b0;
      pstop_r <= 1'b0;
      paddr_r <= '0;
      pval_r <= 16'h0000;
    end else begin
      pstart_r <= take_start | (pstart_r & ~fall_now);
      pcfg_r <= take_cfg | (pcfg_r & ~fall_now);
      pstop_r <= (stop & (st_r == H_RUN)) | (pstop_r & ~(fall_now & ~pstart_r));
      paddr_r <= take_start ? start_addr : paddr_r;
      pval_r <= take_cfg ? cfg_value : pval_r;
    end
  end

  // Pin sequencer, acting on falling edges.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      st_r <= H_IDLE;
      cs_n_r <= 1'b1;
      avd_n_r <= 1'b1;
      we_n_r <= 1'b1;
      oe_r <= 1'b0;
      addr_r <= '0;
      dqo_r <= 16'h0000;
    end else if (fall_now) begin
      if (pcfg_r) begin
        st_r <= H_CFG;
        cs_n_r <= 1'b0;
        we_n_r <= 1'b0;
        oe_r <= 1'b1;
        dqo_r <= pval_r;
      end else if (pstart_r) begin
        st_r <= H_AVD;
        cs_n_r <= 1'b0;
        avd_n_r <= 1'b0;
        addr_r <= paddr_r;
      end else begin
        case (st_r)
          H_CFG: begin
            st_r <= H_IDLE;
            cs_n_r <= 1'b1;
            we_n_r <= 1'b1;
            oe_r <= 1'b0;
          end
          H_AVD: begin
            st_r <= H_RUN;
            avd_n_r <= 1'b1;
          end
          H_RUN: begin
            if (pstop_r) begin
              st_r <= H_IDLE;
              cs_n_r <= 1'b1;
            end
          end
          default: st_r <= H_IDLE;
        endcase
      end
    end
  end

  // Word capture just before each rising edge while running.
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wvalid_r <= 1'b0;
      wdata_r <= 16'h0000;
      lrst_n_r <= 1'b0;
    end else begin
      wvalid_r <= rise_now & (st_r == H_RUN) & sy2_r[16];
      wdata_r <= (rise_now & sy2_r[16]) ? sy2_r[15:0] : wdata_r;
      lrst_n_r <= ~link_reset_req;
    end
  end

  // Outputs.
  assign link.burst_clk = bclk_r;
  assign link.chip_sel_n = cs_n_r;
  assign link.address_valid_strobe_n = avd_n_r;
  assign link.cfg_write_n = we_n_r;
  assign link.link_reset_n = lrst_n_r;
  assign link.addr = addr_r;
  assign link.dq_host = dqo_r;
  assign link.dq_host_oe = oe_r;
  assign word_valid = wvalid_r;
  assign word_data = wdata_r;
  assign busy = (st_r != H_IDLE) | pstart_r | pcfg_r;

endmodule

//--- logic/fcb_device.sv
`timescale 1ns/10ps
// Purpose: Flash end; asynchronous reads and continuous synchronous burst.
// Assumes: Array read data arrives combinationally for the address presented.
// Notes: Link pins are sampled through two flip-flops; edges found on the sampled clock.
module fcb_device
  import fcb_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int BANK_W = BANK_W_DEF
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Memory array port.
  output logic [ADDR_W-1:0] array_addr,
  input wire logic [15:0] array_data,
  // Bank state.
  input wire logic [(1<<BANK_W)-1:0] bank_busy,
  input wire logic [15:0] status_word,
  // Observed mode.
  output logic sync_mode,
  output logic in_status,
  // Link pins.
  fcb_link_if.dev link
);

  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_LAT = 3'b001,
    D_BURST = 3'b010,
    D_WAIT = 3'b011,
    D_STAT = 3'b100,
    D_ASYNC = 3'b101
  } fcb_dst_e;

  localparam int SW = ADDR_W + 21;

  // ****************************************
  // Pin sampling
  // ****************************************
  logic [SW-1:0] sy1_r, sy2_r;
  logic bclk_d_r;

  // Two flip-flops on every link input; all bits travel together.
  always_ff @(posedge clock) begin
    sy1_r <= {link.burst_clk, link.chip_sel_n, link.address_valid_strobe_n,
              link.cfg_write_n, link.link_reset_n, link.addr, link.dq};
    sy2_r <= sy1_r;
    bclk_d_r <= sy2_r[SW-1];
  end

  wire bclk_s = sy2_r[SW-1];
  wire cs_n_s = sy2_r[SW-2];
  wire avd_n_s = sy2_r[SW-3];
  wire we_n_s = sy2_r[SW-4];
  wire lrst_n_s = sy2_r[SW-5];
  wire [ADDR_W-1:0] addr_s = sy2_r[ADDR_W+15:16];
  wire [15:0] dq_s = sy2_r[15:0];

  // ****************************************
  // State
  // ****************************************
  fcb_dst_e st_r, st_nxt;
  logic [15:0] cfg_r, cfg_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [2:0] extra_r, extra_nxt;
  logic first_r, first_nxt;
  logic [15:0] dq_r, dq_nxt;
  logic oe_r, oe_nxt;
  logic rdy_r, rdy_nxt;

  // Decoded conditions.
  wire edge_s = bclk_s & ~bclk_d_r;
  wire async_mode = cfg_r[READ_MODE_POS];
  wire [3:0] ws = {1'b0, cfg_r[WAIT_LSB+WAIT_W-1:WAIT_LSB]} + WAIT_BASE;
  wire cfg_hit = edge_s & ~cs_n_s & ~we_n_s;
  wire start_hit = edge_s & ~cs_n_s & ~avd_n_s & we_n_s;
  wire [BANK_W-1:0] cur_bank = addr_r[ADDR_W-1 -: BANK_W];
  wire bank_start = (addr_r[ADDR_W-BANK_W-1:0] == '0);
  wire into_busy = bank_start & ~first_r & bank_busy[cur_bank];
  wire at_pen = (addr_r[6:0] == PEN_WORD) & ~first_r & (extra_r != 3'h0);
  wire [ADDR_W-1:0] addr_inc = addr_r + ADDR_W'(1);

  // Next state of the read path; bursts step one burst clock edge at a time, asynchronous reads every clock.
  always_comb begin
    st_nxt = st_r;
    cfg_nxt = cfg_r;
    addr_nxt = addr_r;
    cnt_nxt = cnt_r;
    extra_nxt = extra_r;
    first_nxt = first_r;
    dq_nxt = dq_r;
    oe_nxt = oe_r;
    rdy_nxt = rdy_r;
    if (cs_n_s) begin
      st_nxt = D_IDLE;
      oe_nxt = 1'b0;
      rdy_nxt = 1'b0;
    end else if (cfg_hit) begin
      cfg_nxt = dq_s;
      st_nxt = D_IDLE;
      oe_nxt = 1'b0;
      rdy_nxt = 1'b0;
    end else if (async_mode) begin
      // Asynchronous reads follow the address pins; bursts are not started.
      st_nxt = D_ASYNC;
      addr_nxt = addr_s;
      dq_nxt = array_data;
      oe_nxt = we_n_s;
      rdy_nxt = 1'b1;
    end else if (start_hit) begin
      st_nxt = D_LAT;
      addr_nxt = addr_s;
      cnt_nxt = ws;
      extra_nxt = fcb_penalty(ws, addr_s[2:0]);
      first_nxt = 1'b1;
      oe_nxt = 1'b0;
      rdy_nxt = 1'b0;
    end else if (edge_s) begin
      case (st_r)
        D_LAT, D_WAIT: begin
          if (cnt_r == 4'h1) begin
            st_nxt = D_BURST;
            dq_nxt = array_data;
            addr_nxt = addr_inc;
            first_nxt = 1'b0;  // Later words get the line and bank checks.
            oe_nxt = 1'b1;
            rdy_nxt = 1'b1;
          end else begin
            cnt_nxt = cnt_r - 4'h1;
            rdy_nxt = 1'b0;
          end
        end
        D_BURST: begin
          if (into_busy) begin
            st_nxt = D_STAT;
            dq_nxt = status_word;
            rdy_nxt = 1'b0;
          end else if (at_pen) begin
            st_nxt = D_WAIT;
            cnt_nxt = {1'b0, extra_r};
            rdy_nxt = 1'b0;
          end else begin
            dq_nxt = array_data;
            addr_nxt = addr_inc;
            first_nxt = 1'b0;
            rdy_nxt = 1'b1;
          end
        end
        D_STAT: dq_nxt = status_word;
        default: st_nxt = D_IDLE;
      endcase
    end else if (st_r == D_STAT) begin
      dq_nxt = status_word;
    end
  end

  // Registers; the link reset pin acts like the system reset.
  always_ff @(posedge clock) begin
    if (!reset_n || !lrst_n_s) begin
      st_r <= D_IDLE;
      cfg_r <= CFG_RESET;
      addr_r <= '0;
      cnt_r <= 4'h0;
      extra_r <= 3'h0;
      first_r <= 1'b0;
      dq_r <= 16'h0000;
      oe_r <= 1'b0;
      rdy_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cfg_r <= cfg_nxt;
      addr_r <= addr_nxt;
      cnt_r <= cnt_nxt;
      extra_r <= extra_nxt;
      first_r <= first_nxt;
      dq_r <= dq_nxt;
      oe_r <= oe_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  // Outputs.
  assign array_addr = addr_r;
  assign link.dq_dev = dq_r;
  assign link.dq_dev_oe = oe_r;
  assign link.ready = rdy_r;
  assign sync_mode = ~async_mode;
  assign in_status = (st_r == D_STAT);

endmodule

//--- tb/fcb_link_asserts.sv
`timescale 1ns/10ps
// Purpose: Pin checks on the link between host and flash ends.
// Assumes: One clock domain; pins sampled on the system clock.
// Notes: Instantiated beside the link; no bind.
module fcb_link_asserts (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Link pins.
  input wire logic burst_clk,
  input wire logic chip_sel_n,
  input wire logic address_valid_strobe_n,
  input wire logic cfg_write_n,
  input wire logic link_reset_n,
  input wire logic [23:0] addr,
  input wire logic dq_host_oe,
  input wire logic dq_dev_oe,
  input wire logic ready
);
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  // The strobe spans one burst period so the device sees one rising edge.
  a_strobe_hold: assert property ($fell(address_valid_strobe_n) |->
    (!address_valid_strobe_n) [*8] ##[1:12] address_valid_strobe_n)
    else $error("strobe pulse length wrong");
  // The start address must not move while it is being latched.
  a_addr_steady: assert property (!address_valid_strobe_n &&
    !$fell(address_valid_strobe_n) |-> $stable(addr))
    else $error("address moved under strobe");
  // A configuration write drives its value with the device selected.
  a_cfg_drive: assert property (!cfg_write_n && !$past(cfg_write_n) |->
    dq_host_oe && !chip_sel_n)
    else $error("config write without bus drive");
  a_cfg_hold: assert property ($fell(cfg_write_n) |-> (!cfg_write_n) [*8])
    else $error("config write too short");
  // Only one end may drive the data bus.
  a_no_fight: assert property (!(dq_host_oe && dq_dev_oe))
    else $error("both ends drive the bus");
  // The divided burst clock keeps its high phase of eight clocks.
  a_bclk_high: assert property ($rose(burst_clk) |-> burst_clk [*8] ##1 !burst_clk)
    else $error("burst clock high phase wrong");
  // Deselect or link reset takes the device off the bus.
  a_cs_quiet: assert property (chip_sel_n [*6] |-> !dq_dev_oe)
    else $error("device drives while deselected");
  a_rst_quiet: assert property ((!link_reset_n) [*6] |-> !dq_dev_oe && !ready)
    else $error("device drives in link reset");

  // Main scenarios.
  cover property ($fell(address_valid_strobe_n));
  cover property ($fell(cfg_write_n));
  cover property ($fell(link_reset_n));
  cover property ($rose(ready) && !chip_sel_n);
endmodule

//--- tb/tb.sv
`timescale 1ns/10ps
// Purpose: Self-checking bench with host and flash ends joined by the link.
// Assumes: Array word is its address low 16 bits xor a fixed mask.
// Notes: Stimulus moves one ns after each rising clock edge.
module tb;
  import fcb_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic start = 1'b0;
  logic stop = 1'b0;
  logic cfg_req = 1'b0;
  logic link_reset_req = 1'b0;
  logic [23:0] start_addr = 24'h00_0000;
  logic [15:0] cfg_value = 16'h0000;
  logic [15:0] bank_busy = 16'h0000;
  logic [15:0] status_word = 16'h0080;
  logic word_valid, busy, sync_mode, in_status;
  logic [15:0] word_data, array_data;
  logic [23:0] array_addr;
  int error_cnt = 0;
  int checked = 0;
  int pen [3][3] = '{'{0, 0, 1}, '{0, 1, 2}, '{1, 2, 3}};

  // ****************************************
  // Ends, link and checker
  // ****************************************
  fcb_link_if #(.ADDR_W(24)) link ();
  fcb_host #(.ADDR_W(24)) u_fcb_host (.clock(clock), .reset_n(reset_n), .start(start),
    .start_addr(start_addr), .stop(stop), .cfg_req(cfg_req), .cfg_value(cfg_value),
    .link_reset_req(link_reset_req), .word_valid(word_valid), .word_data(word_data),
    .busy(busy), .link(link));
  fcb_device #(.ADDR_W(24), .BANK_W(4)) u_fcb_device (.clock(clock), .reset_n(reset_n),
    .array_addr(array_addr), .array_data(array_data), .bank_busy(bank_busy),
    .status_word(status_word), .sync_mode(sync_mode), .in_status(in_status), .link(link));
  fcb_link_asserts u_fcb_link_asserts (.clock(clock), .reset_n(reset_n),
    .burst_clk(link.burst_clk), .chip_sel_n(link.chip_sel_n),
    .address_valid_strobe_n(link.address_valid_strobe_n), .cfg_write_n(link.cfg_write_n),
    .link_reset_n(link.link_reset_n), .addr(link.addr), .dq_host_oe(link.dq_host_oe),
    .dq_dev_oe(link.dq_dev_oe), .ready(link.ready));

  // The array answers in the same cycle with a word tied to its address.
  assign array_data = array_addr[15:0] ^ 16'hA5C3;

  // ****************************************
  // Tasks
  // ****************************************
  function automatic logic [15:0] ex(input logic [23:0] a);
    return a[15:0] ^ 16'hA5C3;
  endfunction

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Waits, bounded, until the host has finished its sequence.
  task automatic wait_idle();
    int n;
    n = 0;
    tick(2);
    while (busy !== 1'b0 && n < 400) begin
      tick(1);
      n++;
    end
    chk("host idle", n < 400, 1);
  endtask

  task automatic do_cfg(input logic [15:0] v);
    cfg_value = v;
    cfg_req = 1'b1;
    tick(1);
    cfg_req = 1'b0;
    wait_idle();
  endtask

  task automatic go(input logic [23:0] a);
    start_addr = a;
    start = 1'b1;
    tick(1);
    start = 1'b0;
  endtask

  task automatic halt();
    stop = 1'b1;
    tick(1);
    stop = 1'b0;
    wait_idle();
  endtask

  // Gap counts the clocks between two word pulses, less one.
  task automatic word(output logic [15:0] d, output int gap);
    gap = 0;
    tick(1);
    while (word_valid !== 1'b1 && gap < 3000) begin
      tick(1);
      gap++;
    end
    chk("word arrives", gap < 3000, 1);
    d = word_data;
  endtask

  task automatic run_chk(input logic [23:0] a, input int n);
    logic [15:0] d;
    int g;
    for (int i = 0; i < n; i++) begin
      word(d, g);
      chk("burst word", d, ex(a + 24'(i)));
    end
  endtask

  task automatic test_done();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****************************************
  // Clock, reset, tests and watchdog
  // ****************************************
  initial begin
    forever #2 clock = ~clock;
  end

  // Main test sequence.
  initial begin
    logic [15:0] d;
    int g;
    tick(6);
    reset_n = 1'b1;
    tick(2);
    chk("sync after reset", sync_mode, 0);
    $display("test reset_default done");
    do_cfg(16'h1800);
    chk("sync after cfg", sync_mode, 1);
    go(24'h00_1230);
    run_chk(24'h00_1230, 4);
    go(24'h00_4440);
    run_chk(24'h00_4440, 3);
    halt();
    tick(10);
    chk("oe after stop", link.dq_dev_oe, 0);
    $display("test burst_abort_stop done");
    go(24'hFF_FFFD);
    run_chk(24'hFF_FFFD, 5);
    halt();
    $display("test wrap done");
    for (int w = 3; w <= 5; w++) begin
      for (int o = 5; o <= 7; o++) begin
        do_cfg(16'((w - 2) << 11));
        go(24'h00_0070 + 24'(o));
        run_chk(24'h00_0070 + 24'(o), 8 - o);
        word(d, g);
        chk("word 120", d, ex(24'h00_0078));
        chk("line gap", g, 2 * BCLK_HALF_CYC * (1 + pen[w - 3][o - 5]) - 1);
        halt();
      end
    end
    $display("test line_penalty done");
    do_cfg(16'h1800);
    bank_busy = 16'h0002;
    go(24'h0F_FFFE);
    run_chk(24'h0F_FFFE, 2);
    tick(80);
    chk("status flag", in_status, 1);
    chk("status bus", link.dq, status_word);
    chk("status ready", link.ready, 0);
    go(24'h00_3000);
    run_chk(24'h00_3000, 2);
    halt();
    $display("test busy_bank done");
    go(24'h00_0200);
    run_chk(24'h00_0200, 2);
    link_reset_req = 1'b1;
    tick(10);
    chk("oe in link reset", link.dq_dev_oe, 0);
    chk("sync in link reset", sync_mode, 0);
    link_reset_req = 1'b0;
    // Asynchronous reads after link reset repeat the same address, no burst.
    word(d, g);
    word(d, g);
    chk("async word", d, ex(24'h00_0200));
    halt();
    do_cfg(16'h1800);
    chk("sync again", sync_mode, 1);
    do_cfg(16'h9800);
    chk("async again", sync_mode, 0);
    $display("test link_reset_mode done");
    test_done();
  end

  // Cuts a hang short well past the expected run time.
  initial begin
    #200000;
    error_cnt++;
    test_done();
  end
endmodule
